// ---- src/dms_consts.svh ----
`ifndef DMS_CONSTS_SVH
`define DMS_CONSTS_SVH

// Link clock divider: one link period per 24 sample clocks
`define DMS_DIV_RATIO      5'd24
`define DMS_DIV_HALF       5'd12

// Register indices on the control port
`define DMS_REG_CTL1       8'h00
`define DMS_REG_CTL2       8'h01
`define DMS_REG_FTW        8'h04
`define DMS_REG_MODB       8'h05
`define DMS_REG_MODA       8'h06
`define DMS_REG_RLOW       8'h07
`define DMS_REG_RHIGH      8'h08
`define DMS_REG_RSTEP_UP   8'h09
`define DMS_REG_RSTEP_DN   8'h0a
`define DMS_REG_RRATE      8'h0b
`define DMS_REG_PROF_F0    8'h0e
`define DMS_REG_PROF_PA0   8'h16

// Control bit positions
`define DMS_CTL1_AMP_KEY   8
`define DMS_CTL2_PROF_EN   23
`define DMS_CTL2_PAR_EN    22
`define DMS_CTL2_RDEST_HI  21
`define DMS_CTL2_RDEST_LO  20
`define DMS_CTL2_RAMP_EN   19
`define DMS_CTL2_MOD_EN    16

// Ramp destination codes
`define DMS_DEST_FREQ      2'd0
`define DMS_DEST_PHASE     2'd1
`define DMS_DEST_AMP       2'd2

// Parallel word split codes on the function pins
`define DMS_FN_FREQ        2'd0
`define DMS_FN_PHASE       2'd1
`define DMS_FN_AMP         2'd2
`define DMS_FN_POLAR       2'd3

`define DMS_RST_WORD       32'h0000_0000
`define DMS_AMP_FULL       12'hfff

`endif

// ---- src/dms_pkg.sv ----
package dms_pkg;

   typedef struct packed {
      logic        dir;
      logic        hold;
      logic [2:0]  psel;
      logic [1:0]  func;
      logic [31:0] data;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } dms_lin_t;

   typedef struct packed {
      logic [4:0]       div;
      logic             sclk;
      logic             tick;
      dms_lin_t         s1;
      dms_lin_t         s2;
      logic [31:0]      ctl1;
      logic [31:0]      ctl2;
      logic [31:0]      frequency_tuning_word;
      logic [31:0]      modb;
      logic [31:0]      moda;
      logic [31:0]      rlow;
      logic [31:0]      rhigh;
      logic [31:0]      rup;
      logic [31:0]      rdn;
      logic [31:0]      rrate;
      logic [7:0][31:0] prof_f;
      logic [7:0][31:0] prof_pa;
      logic [31:0]      racc;
      logic [15:0]      rcnt;
      logic             rlim;
      logic [31:0]      aux;
      logic             mcarry;
      logic [31:0]      pacc;
      logic [31:0]      freq;
      logic [15:0]      phase;
      logic [11:0]      amp;
   } dms_dev_st_t;

   typedef struct packed {
      logic             sc1;
      logic             sc2;
      logic             sc3;
      logic             lim1;
      logic             lim2;
      logic             dir;
      logic             hold;
      logic [2:0]       psel;
      logic [1:0]       func;
      logic [31:0]      data;
      logic             wr;
      logic [7:0]       addr;
      logic [31:0]      wdata;
      logic             cfg_busy;
      logic [7:0]       cfg_addr;
      logic [31:0]      cfg_data;
      logic             cfg_rdy;
      logic [1:0][31:0] buf_mem;
      logic             buf_head;
      logic [1:0]       buf_cnt;
      logic             word_rdy;
      logic             lim;
   } dms_host_st_t;

endpackage

// ---- src/dms_link_if.sv ----
`timescale 1ns/10ps
interface dms_link_if;
   logic        sync_clk;
   logic        ramp_direction;
   logic        ramp_hold;
   logic        ramp_limit_flag;
   logic [2:0]  profile_select;
   logic [1:0]  func_pins;
   logic [31:0] par_data;
   logic        cfg_wr;
   logic [7:0]  cfg_addr;
   logic [31:0] cfg_wdata;

   modport dev (
      output sync_clk,
      output ramp_limit_flag,
      input  ramp_direction,
      input  ramp_hold,
      input  profile_select,
      input  func_pins,
      input  par_data,
      input  cfg_wr,
      input  cfg_addr,
      input  cfg_wdata
   );

   modport host (
      input  sync_clk,
      input  ramp_limit_flag,
      output ramp_direction,
      output ramp_hold,
      output profile_select,
      output func_pins,
      output par_data,
      output cfg_wr,
      output cfg_addr,
      output cfg_wdata
   );
endinterface

// ---- src/dms_dev.sv ----
`timescale 1ns/10ps
`include "dms_consts.svh"
module dms_dev (
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   dms_link_if.dev          link,
   output logic [31:0]      core_freq_out,
   output logic [15:0]      core_phase_out,
   output logic [11:0]      core_amp_out,
   output logic [31:0]      phase_acc_out,
   output logic             ramp_limit_out
);
   import dms_pkg::*;

   dms_dev_st_t q;
   dms_dev_st_t d;

   // Does the parallel word carry the given parameter under this split
   function automatic logic par_hits(input logic [1:0] fn, input logic [1:0] dest);
      logic hit;
      hit = 1'b0;
      unique case (dest)
         `DMS_DEST_FREQ:  hit = (fn == `DMS_FN_FREQ);
         `DMS_DEST_PHASE: hit = (fn == `DMS_FN_PHASE) || (fn == `DMS_FN_POLAR);
         `DMS_DEST_AMP:   hit = (fn == `DMS_FN_AMP) || (fn == `DMS_FN_POLAR);
         default:         hit = 1'b0;
      endcase
      return hit;
   endfunction

   logic        mod_en;
   logic        ramp_en;
   logic        prof_en;
   logic        par_en;
   logic        amp_key;
   logic [1:0]  rdest;
   logic        ramp_f;
   logic        ramp_p;
   logic        ramp_a;
   logic [31:0] pf;
   logic [31:0] ppa;
   logic [15:0] par_ph;
   logic [11:0] par_am;
   logic [32:0] up_sum;
   logic [32:0] dn_dif;
   logic [32:0] aux_sum;

   always_comb begin
      mod_en  = q.ctl2[`DMS_CTL2_MOD_EN];
      ramp_en = q.ctl2[`DMS_CTL2_RAMP_EN] && !mod_en;
      prof_en = q.ctl2[`DMS_CTL2_PROF_EN];
      par_en  = q.ctl2[`DMS_CTL2_PAR_EN];
      amp_key = q.ctl1[`DMS_CTL1_AMP_KEY];
      rdest   = q.ctl2[`DMS_CTL2_RDEST_HI:`DMS_CTL2_RDEST_LO];
      ramp_f  = ramp_en && (rdest == `DMS_DEST_FREQ);
      ramp_p  = ramp_en && (rdest == `DMS_DEST_PHASE);
      ramp_a  = ramp_en && (rdest == `DMS_DEST_AMP);
      pf      = q.prof_f[q.s2.psel];
      ppa     = q.prof_pa[q.s2.psel];
      // Polar split puts phase in the high half, amplitude below it
      par_ph  = q.s2.data[31:16];
      par_am  = (q.s2.func == `DMS_FN_POLAR) ? q.s2.data[15:4] : q.s2.data[31:20];
      up_sum  = {1'b0, q.racc} + {1'b0, q.rup};
      dn_dif  = {1'b0, q.racc} - {1'b0, q.rdn};
      aux_sum = {1'b0, q.aux} + {1'b0, q.moda};
   end

   always_comb begin
      d = q;
      ////////////////////////////////////////////////////////////////////////
      // Port clock generation and input capture
      d.div  = (q.div == `DMS_DIV_RATIO - 5'd1) ? 5'd0 : q.div + 5'd1;
      d.sclk = (d.div < `DMS_DIV_HALF);
      d.tick = (q.div == `DMS_DIV_RATIO - 5'd1);
      d.s1.dir   = link.ramp_direction;
      d.s1.hold  = link.ramp_hold;
      d.s1.psel  = link.profile_select;
      d.s1.func  = link.func_pins;
      d.s1.data  = link.par_data;
      d.s1.wr    = link.cfg_wr;
      d.s1.addr  = link.cfg_addr;
      d.s1.wdata = link.cfg_wdata;
      d.s2   = q.s1;

      ////////////////////////////////////////////////////////////////////////
      // Everything down to the phase accumulator acts once per port clock rising edge
      if (q.tick) begin
         if (q.s2.wr) begin
            unique case (q.s2.addr)
               `DMS_REG_CTL1:      d.ctl1  = q.s2.wdata;
               `DMS_REG_CTL2:      d.ctl2  = q.s2.wdata;
               `DMS_REG_FTW:       d.frequency_tuning_word   = q.s2.wdata;
               `DMS_REG_MODB:      d.modb  = q.s2.wdata;
               `DMS_REG_MODA:      d.moda  = q.s2.wdata;
               `DMS_REG_RLOW:      d.rlow  = q.s2.wdata;
               `DMS_REG_RHIGH:     d.rhigh = q.s2.wdata;
               `DMS_REG_RSTEP_UP:  d.rup   = q.s2.wdata;
               `DMS_REG_RSTEP_DN:  d.rdn   = q.s2.wdata;
               `DMS_REG_RRATE:     d.rrate = q.s2.wdata;
               default: begin
                  if (q.s2.addr >= `DMS_REG_PROF_F0 && q.s2.addr < `DMS_REG_PROF_PA0) begin
                     d.prof_f[q.s2.addr[2:0] - 3'd6] = q.s2.wdata;
                  end else if (q.s2.addr >= `DMS_REG_PROF_PA0
                               && q.s2.addr < `DMS_REG_PROF_PA0 + 8'd8) begin
                     d.prof_pa[q.s2.addr[2:0] - 3'd6] = q.s2.wdata;
                  end
               end
            endcase
         end

         // Ramp generator; rate counts port clocks between steps
         if (!ramp_en) begin
            d.racc = q.rlow;
            d.rcnt = 16'h0000;
            d.rlim = 1'b0;
         end else if (!q.s2.hold) begin
            if (q.rcnt == 16'h0000) begin
               if (q.s2.dir) begin
                  d.rcnt = q.rrate[15:0];
                  d.racc = (up_sum[32] || up_sum[31:0] >= q.rhigh) ? q.rhigh : up_sum[31:0];
               end else begin
                  d.rcnt = q.rrate[31:16];
                  d.racc = (dn_dif[32] || dn_dif[31:0] <= q.rlow) ? q.rlow : dn_dif[31:0];
               end
            end else begin
               d.rcnt = q.rcnt - 16'h0001;
            end
         end
         // Flag follows position, so a ramp held at a limit still shows it
         d.rlim = ramp_en && ((d.racc == q.rhigh) || (d.racc == q.rlow));

         // Source selection, highest precedence first
         if (mod_en) begin
            d.freq = q.frequency_tuning_word;
         end else if (ramp_f) begin
            d.freq = q.racc;
         end else if (prof_en) begin
            d.freq = pf;
         end else if (par_en && par_hits(q.s2.func, `DMS_DEST_FREQ)) begin
            d.freq = q.s2.data;
         end else begin
            d.freq = pf;
         end

         if (ramp_p) begin
            d.phase = q.racc[31:16];
         end else if (prof_en) begin
            d.phase = ppa[15:0];
         end else if (par_en && par_hits(q.s2.func, `DMS_DEST_PHASE)) begin
            d.phase = par_ph;
         end else begin
            d.phase = ppa[15:0];
         end

         // Without amplitude keying the scaler sits at full scale
         if (!amp_key) begin
            d.amp = `DMS_AMP_FULL;
         end else if (ramp_a) begin
            d.amp = q.racc[31:20];
         end else if (prof_en) begin
            d.amp = ppa[27:16];
         end else if (par_en && par_hits(q.s2.func, `DMS_DEST_AMP)) begin
            d.amp = par_am;
         end else begin
            d.amp = ppa[27:16];
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Phase accumulator with modulus carry, every sample clock
      // A, B assumed legal (A < B, B >= 2) while modulus is on
      d.mcarry = 1'b0;
      if (mod_en) begin
         if (aux_sum >= {1'b0, q.modb}) begin
            d.aux    = 32'(aux_sum - {1'b0, q.modb});
            d.mcarry = 1'b1;
         end else begin
            d.aux = aux_sum[31:0];
         end
      end else begin
         d.aux = `DMS_RST_WORD;
      end
      d.pacc = q.pacc + q.freq + {31'd0, q.mcarry};

      if (sys_rst_in) begin
         d = '0;
         d.amp = `DMS_AMP_FULL;
         // Wrap on the first edge out of reset, so the first high phase is full length
         d.div = `DMS_DIV_RATIO - 5'd1;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      q <= d;
   end

   assign link.sync_clk        = q.sclk;
   assign link.ramp_limit_flag = q.rlim;
   assign core_freq_out        = q.freq;
   assign core_phase_out       = q.phase;
   assign core_amp_out         = q.amp;
   assign phase_acc_out        = q.pacc;
   assign ramp_limit_out       = q.rlim;
endmodule

// ---- src/dms_host.sv ----
`timescale 1ns/10ps
`include "dms_consts.svh"
module dms_host (
   input  wire logic        sys_clk_in,
   input  wire logic        sys_rst_in,
   dms_link_if.host         link,
   input  wire logic        ramp_dir_in,
   input  wire logic        ramp_hold_in,
   input  wire logic [2:0]  profile_sel_in,
   input  wire logic [1:0]  func_sel_in,
   input  wire logic        word_valid_in,
   input  wire logic [31:0] word_in,
   output logic             word_ready_out,
   input  wire logic        cfg_valid_in,
   input  wire logic [7:0]  cfg_addr_in,
   input  wire logic [31:0] cfg_data_in,
   output logic             cfg_ready_out,
   output logic             ramp_limit_out
);
   import dms_pkg::*;

   dms_host_st_t q;
   dms_host_st_t d;

   logic edge_seen;
   logic push;
   logic pop;

   always_comb begin
      d = q;
      d.sc1  = link.sync_clk;
      d.sc2  = q.sc1;
      d.sc3  = q.sc2;
      d.lim1 = link.ramp_limit_flag;
      d.lim2 = q.lim1;
      d.lim  = q.lim2;
      // Launch just after the device's rising edge, so the word is settled by the next one
      edge_seen = q.sc2 && !q.sc3;
      push      = word_valid_in && q.word_rdy;
      pop       = edge_seen && (q.buf_cnt != 2'd0);

      if (cfg_valid_in && q.cfg_rdy) begin
         d.cfg_busy = 1'b1;
         d.cfg_addr = cfg_addr_in;
         d.cfg_data = cfg_data_in;
      end

      if (edge_seen) begin
         d.dir  = ramp_dir_in;
         d.hold = ramp_hold_in;
         d.psel = profile_sel_in;
         d.func = func_sel_in;
         d.wr   = q.cfg_busy;
         if (q.cfg_busy) begin
            d.addr     = q.cfg_addr;
            d.wdata    = q.cfg_data;
            d.cfg_busy = 1'b0;
         end
         if (pop) begin
            d.data     = q.buf_mem[q.buf_head];
            d.buf_head = !q.buf_head;
         end
      end

      // Two-entry buffer; a word held back stays until the link drains it
      if (push) begin
         d.buf_mem[q.buf_head ^ q.buf_cnt[0]] = word_in;
      end
      d.buf_cnt  = 2'(q.buf_cnt + {1'b0, push} - {1'b0, pop});
      d.word_rdy = (d.buf_cnt < 2'd2);
      d.cfg_rdy  = !d.cfg_busy;

      if (sys_rst_in) begin
         d = '0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      q <= d;
   end

   assign link.ramp_direction = q.dir;
   assign link.ramp_hold      = q.hold;
   assign link.profile_select = q.psel;
   assign link.func_pins      = q.func;
   assign link.par_data       = q.data;
   assign link.cfg_wr         = q.wr;
   assign link.cfg_addr       = q.addr;
   assign link.cfg_wdata      = q.wdata;
   assign word_ready_out      = q.word_rdy;
   assign cfg_ready_out       = q.cfg_rdy;
   assign ramp_limit_out      = q.lim;
endmodule

// ---- verification/dms_assertions.sv ----
`timescale 1ns/10ps
module dms_assertions (
   input wire logic        sys_clk_in,
   input wire logic        sys_rst_in,
   input wire logic        sync_clk,
   input wire logic        ramp_limit_flag,
   input wire logic        ramp_direction,
   input wire logic        ramp_hold,
   input wire logic [2:0]  profile_select,
   input wire logic [1:0]  func_pins,
   input wire logic [31:0] par_data,
   input wire logic        cfg_wr,
   input wire logic [7:0]  cfg_addr,
   input wire logic [31:0] cfg_wdata
);
   logic [4:0] per_q;
   logic       sc_q;
   logic       seen_q;
   logic       sc_rise;

   assign sc_rise = sync_clk && !sc_q;

   // Cycles since the last port clock rise
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         per_q <= 5'h00;
         sc_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         per_q <= sc_rise ? 5'h00 : per_q + 5'h01;
         sc_q <= sync_clk;
         seen_q <= seen_q | sc_rise;
      end
   end

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   ////////////////////////////////////////////////////////////////////////////////
   chk_sync_period: assert property (sc_rise && seen_q |-> per_q == 5'h17)
      else $error("port clock period is not 24 cycles");
   chk_sync_high: assert property ($rose(sync_clk) |->
      sync_clk [*8] ##1 sync_clk [*4] ##1 !sync_clk)
      else $error("port clock high time is not 12 cycles");
   chk_sync_low: assert property ($fell(sync_clk) |->
      !sync_clk [*8] ##1 !sync_clk [*4] ##1 sync_clk)
      else $error("port clock low time is not 12 cycles");
   chk_cfg_align: assert property ($changed(cfg_wr) |-> per_q inside {[5'h01:5'h0a]})
      else $error("write strobe moved away from port clock rise");
   chk_cfg_hold: assert property ($rose(cfg_wr) |=>
      (cfg_wr && $stable(cfg_addr) && $stable(cfg_wdata)) [*8])
      else $error("register write not held");
   chk_data_align: assert property ($changed(par_data) |-> per_q inside {[5'h01:5'h0a]})
      else $error("parallel word moved away from port clock rise");
   chk_pins_align: assert property ($changed({ramp_direction, ramp_hold, profile_select,
      func_pins}) |-> per_q inside {[5'h01:5'h0a]})
      else $error("control pins moved away from port clock rise");
   chk_flag_align: assert property (seen_q && $changed(ramp_limit_flag) |->
      per_q < 5'h04 || per_q == 5'h17)
      else $error("limit flag changed between port ticks");

   cover property ($rose(cfg_wr));
   cover property ($changed(par_data));
   cover property ($rose(ramp_limit_flag));
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb;
   logic        sys_clk_in  = 1'b0;
   logic        sys_rst_in  = 1'b1;
   logic        dir         = 1'b1;
   logic        hold        = 1'b0;
   logic [2:0]  psel        = 3'h0;
   logic [1:0]  func        = 2'h0;
   logic        word_valid  = 1'b0;
   logic [31:0] word        = 32'h0;
   logic        cfg_valid   = 1'b0;
   logic [7:0]  cfg_addr    = 8'h00;
   logic [31:0] cfg_data    = 32'h0;
   logic        word_ready;
   logic        cfg_ready;
   logic        lim_host;
   logic        lim_dev;
   logic [31:0] freq;
   logic [15:0] phase;
   logic [11:0] amp;
   logic [31:0] pacc;
   logic [31:0] p;
   logic [31:0] w;
   int          mismatches  = 0;
   int          n_checks    = 0;
   int          cycles      = 0;

   dms_link_if link ();
   dms_dev i_dms_dev (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link(link),
      .core_freq_out(freq), .core_phase_out(phase), .core_amp_out(amp),
      .phase_acc_out(pacc), .ramp_limit_out(lim_dev));
   dms_host i_dms_host (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link(link),
      .ramp_dir_in(dir), .ramp_hold_in(hold), .profile_sel_in(psel), .func_sel_in(func),
      .word_valid_in(word_valid), .word_in(word), .word_ready_out(word_ready),
      .cfg_valid_in(cfg_valid), .cfg_addr_in(cfg_addr), .cfg_data_in(cfg_data),
      .cfg_ready_out(cfg_ready), .ramp_limit_out(lim_host));
   dms_assertions u_chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .sync_clk(link.sync_clk), .ramp_limit_flag(link.ramp_limit_flag),
      .ramp_direction(link.ramp_direction), .ramp_hold(link.ramp_hold),
      .profile_select(link.profile_select), .func_pins(link.func_pins),
      .par_data(link.par_data), .cfg_wr(link.cfg_wr), .cfg_addr(link.cfg_addr),
      .cfg_wdata(link.cfg_wdata));

   always #5 sys_clk_in = ~sys_clk_in;

   // Whole run needs about 2000 cycles
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One valid/ready transfer: c selects register write, else parallel word
   task automatic xfer(input bit c, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(negedge sys_clk_in);
      if (c) {cfg_valid, cfg_addr, cfg_data} = {1'b1, a, d};
      else {word_valid, word} = {1'b1, d};
      n = 0;
      while ((c ? cfg_ready : word_ready) !== 1'b1 && n < 300) begin
         @(negedge sys_clk_in);
         n++;
      end
      if (n == 300) mismatches++;
      @(negedge sys_clk_in);
      cfg_valid = 1'b0;
      word_valid = 1'b0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge link.sync_clk);
      @(negedge sys_clk_in);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      sys_rst_in = 1'b0;
      check("freq", 32'h0, freq);
      check("amp", 32'h0fff, {20'h0, amp});
      xfer(1, 8'h00, 32'h0000_0100);
      xfer(1, 8'h0e, 32'h1234_5678);
      xfer(1, 8'h16, 32'h0abc_4321);
      xfer(1, 8'h0f, 32'h0000_1111);
      xfer(1, 8'h01, 32'h0080_0000);
      settle(4);
      check("freq", 32'h1234_5678, freq);
      check("phase", 32'h4321, {16'h0, phase});
      check("amp", 32'h0abc, {20'h0, amp});
      psel = 3'h1;
      settle(3);
      check("freq", 32'h0000_1111, freq);
      xfer(1, 8'h01, 32'h00c0_0000);
      xfer(0, 8'h00, 32'hdead_beef);
      settle(4);
      check("freq", 32'h0000_1111, freq);
      xfer(1, 8'h01, 32'h0040_0000);
      settle(4);
      check("freq", 32'hdead_beef, freq);
      for (int f = 0; f < 4; f++) begin
         func = f[1:0];
         w = 32'h8765_4321 + f * 32'h1111_1111;
         xfer(0, 8'h00, w);
         settle(4);
         if (f == 0) check("freq", w, freq);
         if (f[0]) check("phase", {16'h0, w[31:16]}, {16'h0, phase});
         if (f == 2) check("amp", {20'h0, w[31:20]}, {20'h0, amp});
         if (f == 3) check("amp", {20'h0, w[15:4]}, {20'h0, amp});
      end
      hold = 1'b1;
      psel = 3'h0;
      xfer(1, 8'h07, 32'h1230_0000);
      xfer(1, 8'h08, 32'h4560_0000);
      xfer(1, 8'h09, 32'h1000_0000);
      xfer(1, 8'h0a, 32'h0800_0000);
      xfer(1, 8'h0b, 32'h0);
      xfer(1, 8'h01, 32'h0088_0000);
      settle(6);
      check("freq", 32'h1230_0000, freq);
      check("limit", 32'h1, {31'h0, lim_dev});
      check("phase", 32'h4321, {16'h0, phase});
      hold = 1'b0;
      settle(8);
      check("freq", 32'h4560_0000, freq);
      check("limit", 32'h1, {31'h0, lim_host});
      dir = 1'b0;
      settle(11);
      check("freq", 32'h1230_0000, freq);
      xfer(1, 8'h01, 32'h0098_0000);
      settle(4);
      check("phase", 32'h1230, {16'h0, phase});
      check("freq", 32'h1234_5678, freq);
      xfer(1, 8'h01, 32'h00a8_0000);
      settle(4);
      check("amp", 32'h0123, {20'h0, amp});
      xfer(1, 8'h00, 32'h0);
      settle(4);
      check("amp", 32'h0fff, {20'h0, amp});
      xfer(1, 8'h00, 32'h0000_0100);
      xfer(1, 8'h04, 32'h4ccc_cccc);
      xfer(1, 8'h05, 32'h0000_0005);
      xfer(1, 8'h06, 32'h0000_0004);
      xfer(1, 8'h01, 32'h0089_0000);
      settle(4);
      check("freq", 32'h4ccc_cccc, freq);
      check("amp", 32'h0abc, {20'h0, amp});
      // Four carries in any five cycles when A is 4 and B is 5
      p = pacc;
      repeat (5) @(negedge sys_clk_in);
      check("phase_acc", p + 32'h8000_0000, pacc);
      p = pacc;
      repeat (10) @(negedge sys_clk_in);
      check("phase_acc", p, pacc);
      summarize();
   end
endmodule
